//--- design/dma_trig_pkg.sv
// Constants shared by the channel trigger and completion logic.
// Assumes one 200 MHz clock domain and a plain register port.
package dma_trig_pkg;
  localparam int CH_W = 6;
  localparam int ADDR_W = 8;
  localparam int NUM_CODES = 64;
  localparam int WORD_W = 32;
  localparam logic [ADDR_W-1:0] OFF_EVENT_LATCH = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EVENT_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_EVENT_SET = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CHAINED_EVENT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_QUICK_EVENT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_QUICK_ENABLE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PENDING_LOW = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PENDING_HIGH = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_CLEAR_LOW = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_CLEAR_HIGH = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_QSEL_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_QMAP_BASE = 8'h60;
  localparam int BLOCK_MSB = 7;
  localparam int BLOCK_LSB = 5;
  localparam int INDEX_MSB = 4;
  localparam int INDEX_LSB = 2;
  localparam int OPT_FINAL_IRQ = 20;
  localparam int OPT_INTER_IRQ = 21;
  localparam int OPT_FINAL_CHAIN = 22;
  localparam int OPT_INTER_CHAIN = 23;
  localparam int OPT_CODE_LSB = 12;
  localparam int CODE_W = 6;
  localparam int QSEL_W = 3;
  localparam int QSEL_STRIDE = 4;
  localparam int QSEL_PER_REG = 8;
  localparam int QMAP_QUEUE_LSB = 16;
  localparam logic [WORD_W-1:0] RESET_WORD = 32'h00000000;
endpackage

//--- design/dma_channel_trigger.sv
// Channel trigger, queue head and completion latching for a DMA controller.
// Assumes pins are asynchronous, engines and set RAM share this clock.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
module dma_channel_trigger #(
  parameter int NUM_CH = 32,
  parameter int NUM_QCH = 8,
  parameter int NUM_Q = 8,
  parameter int SET_ADDR_W = 14
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [dma_trig_pkg::ADDR_W-1:0] regAddr,
  input wire logic [dma_trig_pkg::WORD_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [dma_trig_pkg::WORD_W-1:0] regRdData,
  input wire logic [NUM_CH-1:0] eventPins,
  input wire logic ramWrite,
  input wire logic [SET_ADDR_W-1:0] ramAddr,
  input wire logic linkUpdate,
  input wire logic [SET_ADDR_W-1:0] linkAddr,
  output logic [NUM_Q-1:0] trqValid,
  output logic [NUM_Q*dma_trig_pkg::CH_W-1:0] trqChannel,
  input wire logic [NUM_Q-1:0] trqReady,
  input wire logic [NUM_Q*dma_trig_pkg::WORD_W-1:0] trqOptions,
  input wire logic [NUM_Q-1:0] doneValid,
  input wire logic [NUM_Q*dma_trig_pkg::WORD_W-1:0] doneOptions
);
  localparam int NTOT = NUM_CH + NUM_QCH;
  localparam int CW = dma_trig_pkg::CH_W;
  localparam int WW = dma_trig_pkg::WORD_W;
  localparam int QW = dma_trig_pkg::QSEL_W;
  localparam int IW = dma_trig_pkg::INDEX_MSB - dma_trig_pkg::INDEX_LSB + 1;

  function automatic logic [CW:0] lowestSet(input logic [NTOT-1:0] v);
    logic [CW:0] r;
    r = '0;
    for (int i = NTOT - 1; i >= 0; i--) begin
      if (v[i]) r = {1'b1, CW'(i)};
    end
    return r;
  endfunction

  // Completion code field of an options word
  function automatic logic [dma_trig_pkg::CODE_W-1:0] codeOf(input logic [WW-1:0] channel_options_word);
    return channel_options_word[dma_trig_pkg::OPT_CODE_LSB +: dma_trig_pkg::CODE_W];
  endfunction

  // Queue select slot addressed by a register index and lane
  function automatic int qselSlot(input logic [IW-1:0] idx, input int lane);
    return int'(idx) * dma_trig_pkg::QSEL_PER_REG + lane;
  endfunction

  logic [NUM_CH-1:0] evSync1, evSync2, evPrev, evLatch, evEnable, setPend, chainEvt;
  logic [NUM_QCH-1:0] quickEvt, quickEnable;
  logic [dma_trig_pkg::NUM_CODES-1:0] pending;
  logic [QW-1:0] qsel [NUM_CH];
  logic [WW-1:0] qmap [NUM_QCH];

  // Pin events pass two flops, then a rising edge is latched
  wire [NUM_CH-1:0] evRise = evSync2 & ~evPrev;
  wire isQsel = regAddr[dma_trig_pkg::BLOCK_MSB:dma_trig_pkg::BLOCK_LSB]
    == dma_trig_pkg::OFF_QSEL_BASE[dma_trig_pkg::BLOCK_MSB:dma_trig_pkg::BLOCK_LSB];
  wire isQmap = regAddr[dma_trig_pkg::BLOCK_MSB:dma_trig_pkg::BLOCK_LSB]
    == dma_trig_pkg::OFF_QMAP_BASE[dma_trig_pkg::BLOCK_MSB:dma_trig_pkg::BLOCK_LSB];
  wire [IW-1:0] regIndex = regAddr[dma_trig_pkg::INDEX_MSB:dma_trig_pkg::INDEX_LSB];
  wire wrSet = regWrite && regAddr == dma_trig_pkg::OFF_EVENT_SET;
  wire wrClrLow = regWrite && regAddr == dma_trig_pkg::OFF_CLEAR_LOW;
  wire wrClrHigh = regWrite && regAddr == dma_trig_pkg::OFF_CLEAR_HIGH;
  // Write-one-to-clear masks
  wire [WW-1:0] clearLow = wrClrLow ? regWrData : dma_trig_pkg::RESET_WORD;
  wire [WW-1:0] clearHigh = wrClrHigh ? regWrData : dma_trig_pkg::RESET_WORD;
  wire [dma_trig_pkg::NUM_CODES-1:0] clearMask = {clearHigh, clearLow};

  // Quick trigger-word writes and link updates
  logic [NUM_QCH-1:0] quickHit;
  always_comb begin
    for (int k = 0; k < NUM_QCH; k++) begin
      quickHit[k] = quickEnable[k] && ((ramWrite && ramAddr == qmap[k][SET_ADDR_W-1:0])
        || (linkUpdate && linkAddr == qmap[k][SET_ADDR_W-1:0]));
    end
  end

  // Candidate channels: DMA need an event, quick need a quick event bit
  wire [NUM_CH-1:0] dmaCand = (evLatch & evEnable) | setPend | chainEvt;
  wire [NTOT-1:0] cand = {quickEvt, dmaCand};

  logic [QW-1:0] chanQueue [NTOT];
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) chanQueue[c] = qsel[c];
    for (int k = 0; k < NUM_QCH; k++) chanQueue[NUM_CH + k] = qmap[k][dma_trig_pkg::QMAP_QUEUE_LSB +: QW];
  end

  wire [NUM_Q-1:0] handed = trqValid & trqReady;
  logic [NUM_Q-1:0] take;
  logic [CW-1:0] pick [NUM_Q];
  logic [NTOT-1:0] accepted;

  for (genvar q = 0; q < NUM_Q; q++) begin : g_queue
    logic [NTOT-1:0] inQueue;
    logic [CW:0] first;
    always_comb begin
      for (int c = 0; c < NTOT; c++) inQueue[c] = chanQueue[c] == QW'(q);
    end
    assign first = lowestSet(cand & inQueue);
    assign take[q] = first[CW] && (!trqValid[q] || trqReady[q]);
    assign pick[q] = first[CW-1:0];
  end

  always_comb begin
    accepted = '0;
    for (int q = 0; q < NUM_Q; q++) begin
      if (take[q]) accepted[pick[q]] = 1'b1;
    end
  end

  // Intermediate completion at hand-over, final from the engine
  logic [dma_trig_pkg::NUM_CODES-1:0] compSet, chainFull;
  logic [WW-1:0] optI [NUM_Q];
  logic [WW-1:0] optF [NUM_Q];
  always_comb begin
    compSet = '0;
    chainFull = '0;
    for (int q = 0; q < NUM_Q; q++) begin
      optI[q] = trqOptions[q*WW +: WW];
      optF[q] = doneOptions[q*WW +: WW];
      if (handed[q] && optI[q][dma_trig_pkg::OPT_INTER_IRQ])
        compSet[codeOf(optI[q])] = 1'b1;
      if (handed[q] && optI[q][dma_trig_pkg::OPT_INTER_CHAIN])
        chainFull[codeOf(optI[q])] = 1'b1;
      if (doneValid[q] && optF[q][dma_trig_pkg::OPT_FINAL_IRQ])
        compSet[codeOf(optF[q])] = 1'b1;
      if (doneValid[q] && optF[q][dma_trig_pkg::OPT_FINAL_CHAIN])
        chainFull[codeOf(optF[q])] = 1'b1;
    end
  end
  wire [NUM_CH-1:0] chainSet = chainFull[NUM_CH-1:0];

  // Register read mux
  logic [WW-1:0] rdValue;
  always_comb begin
    rdValue = dma_trig_pkg::RESET_WORD;
    if (isQsel) begin
      for (int j = 0; j < dma_trig_pkg::QSEL_PER_REG; j++) begin
        if (qselSlot(regIndex, j) < NUM_CH)
          rdValue[j*dma_trig_pkg::QSEL_STRIDE +: QW] = qsel[qselSlot(regIndex, j)];
      end
    end else if (isQmap) begin
      if (int'(regIndex) < NUM_QCH) rdValue = qmap[regIndex];
    end else begin
      unique case (regAddr)
        dma_trig_pkg::OFF_EVENT_LATCH: rdValue[NUM_CH-1:0] = evLatch;
        dma_trig_pkg::OFF_EVENT_ENABLE: rdValue[NUM_CH-1:0] = evEnable;
        dma_trig_pkg::OFF_CHAINED_EVENT: rdValue[NUM_CH-1:0] = chainEvt;
        dma_trig_pkg::OFF_QUICK_EVENT: rdValue[NUM_QCH-1:0] = quickEvt;
        dma_trig_pkg::OFF_QUICK_ENABLE: rdValue[NUM_QCH-1:0] = quickEnable;
        dma_trig_pkg::OFF_PENDING_LOW: rdValue = pending[WW-1:0];
        dma_trig_pkg::OFF_PENDING_HIGH: rdValue = pending[2*WW-1:WW];
        default: rdValue = dma_trig_pkg::RESET_WORD;
      endcase
    end
  end

  // Event, quick and pending state; a set wins over a clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      evSync1 <= '0;
      evSync2 <= '0;
      evPrev <= '0;
      evLatch <= '0;
      setPend <= '0;
      chainEvt <= '0;
      quickEvt <= '0;
      pending <= '0;
      regRdData <= dma_trig_pkg::RESET_WORD;
    end else begin
      evSync1 <= eventPins;
      evSync2 <= evSync1;
      evPrev <= evSync2;
      evLatch <= (evLatch & ~accepted[NUM_CH-1:0]) | evRise;
      setPend <= (setPend & ~accepted[NUM_CH-1:0]) | (wrSet ? regWrData[NUM_CH-1:0] : '0);
      chainEvt <= (chainEvt & ~accepted[NUM_CH-1:0]) | chainSet;
      quickEvt <= (quickEvt & ~accepted[NTOT-1:NUM_CH]) | quickHit;
      pending <= (pending & ~clearMask) | compSet;
      regRdData <= regRead ? rdValue : dma_trig_pkg::RESET_WORD;
    end
  end

  // Control registers written by software
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      evEnable <= '0;
      quickEnable <= '0;
      for (int c = 0; c < NUM_CH; c++) qsel[c] <= '0;
      for (int k = 0; k < NUM_QCH; k++) qmap[k] <= dma_trig_pkg::RESET_WORD;
    end else if (regWrite) begin
      if (regAddr == dma_trig_pkg::OFF_EVENT_ENABLE) evEnable <= regWrData[NUM_CH-1:0];
      if (regAddr == dma_trig_pkg::OFF_QUICK_ENABLE) quickEnable <= regWrData[NUM_QCH-1:0];
      if (isQmap && int'(regIndex) < NUM_QCH) qmap[regIndex] <= regWrData;
      for (int j = 0; j < dma_trig_pkg::QSEL_PER_REG; j++) begin
        if (isQsel && qselSlot(regIndex, j) < NUM_CH)
          qsel[qselSlot(regIndex, j)] <= regWrData[j*dma_trig_pkg::QSEL_STRIDE +: QW];
      end
    end
  end

  // Queue head slots, one per transfer engine
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      trqValid <= '0;
      trqChannel <= '0;
    end else begin
      for (int q = 0; q < NUM_Q; q++) begin
        if (take[q]) begin
          trqValid[q] <= 1'b1;
          trqChannel[q*CW +: CW] <= pick[q];
        end else if (trqReady[q]) begin
          trqValid[q] <= 1'b0;
        end
      end
    end
  end

  a_event_latch_set: assert property (
    @(posedge clock) disable iff (sys_rst)
    evRise != '0 |=> (evLatch & $past(evRise)) == $past(evRise))
    else $error("pin event not latched");
  a_set_write_queues: assert property (
    @(posedge clock) disable iff (sys_rst)
    wrSet |=> (setPend & $past(regWrData[NUM_CH-1:0])) == $past(regWrData[NUM_CH-1:0]))
    else $error("event set write lost");
  a_chain_sets_bit: assert property (
    @(posedge clock) disable iff (sys_rst)
    chainSet != '0 |=> (chainEvt & $past(chainSet)) == $past(chainSet))
    else $error("chained event not set");
  a_quick_hit_sets: assert property (
    @(posedge clock) disable iff (sys_rst)
    quickHit != '0 |=> (quickEvt & $past(quickHit)) == $past(quickHit))
    else $error("quick trigger not set");
  a_quick_only_hit: assert property (
    @(posedge clock) disable iff (sys_rst)
    ##1 (quickEvt & ~$past(quickEvt) & ~$past(quickHit)) == '0)
    else $error("quick event without trigger");
  a_pending_latch: assert property (
    @(posedge clock) disable iff (sys_rst)
    compSet != '0 |=> (pending & $past(compSet)) == $past(compSet))
    else $error("completion not latched");
  a_pending_clear: assert property (
    @(posedge clock) disable iff (sys_rst)
    wrClrLow && compSet[WW-1:0] == '0 |=> (pending[WW-1:0] & $past(regWrData)) == '0)
    else $error("pending bit not cleared");
  a_head_holds: assert property (
    @(posedge clock) disable iff (sys_rst)
    trqValid[0] && !trqReady[0] |=> trqValid[0] && $stable(trqChannel[CW-1:0]))
    else $error("request dropped before hand-over");
  a_inter_complete: assert property (
    @(posedge clock) disable iff (sys_rst)
    handed[0] && trqOptions[dma_trig_pkg::OPT_INTER_IRQ] |=>
      pending[$past(trqOptions[dma_trig_pkg::OPT_CODE_LSB +: dma_trig_pkg::CODE_W])])
    else $error("intermediate completion missing");
  // Completion, queue and link checks
  a_final_complete: assert property (
    @(posedge clock) disable iff (sys_rst)
    doneValid[0] && doneOptions[dma_trig_pkg::OPT_FINAL_IRQ] |=>
      pending[$past(codeOf(doneOptions[WW-1:0]))])
    else $error("final completion missing");
  a_pending_source: assert property (
    @(posedge clock) disable iff (sys_rst)
    1'b1 |=> (pending & ~$past(pending) & ~$past(compSet)) == '0)
    else $error("pending bit set without completion");
  a_clear_keeps: assert property (
    @(posedge clock) disable iff (sys_rst)
    wrClrLow |=> ($past(pending[WW-1:0]) & ~$past(regWrData) & ~pending[WW-1:0]) == '0)
    else $error("pending bit lost on zero write");
  a_pending_read: assert property (
    @(posedge clock) disable iff (sys_rst)
    regRead && regAddr == dma_trig_pkg::OFF_PENDING_HIGH |=>
      regRdData == $past(pending[2*WW-1:WW]))
    else $error("high pending read wrong");
  a_disabled_waits: assert property (
    @(posedge clock) disable iff (sys_rst)
    1'b1 |=> ($past(evLatch & ~evEnable & ~setPend & ~chainEvt) & ~evLatch) == '0)
    else $error("disabled event lost");
  a_lowest_first: assert property (
    @(posedge clock) disable iff (sys_rst)
    take[0] && cand[0] && chanQueue[0] == '0 |-> pick[0] == '0)
    else $error("lower channel passed over");
  a_queue_route: assert property (
    @(posedge clock) disable iff (sys_rst)
    take[0] |-> chanQueue[pick[0]] == '0)
    else $error("channel taken by wrong queue");
  a_link_sets: assert property (
    @(posedge clock) disable iff (sys_rst)
    linkUpdate && quickEnable[0] && linkAddr == qmap[0][SET_ADDR_W-1:0] |=> quickEvt[0])
    else $error("link update did not trigger");
  a_head_release: assert property (
    @(posedge clock) disable iff (sys_rst)
    trqValid[0] && trqReady[0] && !take[0] |=> !trqValid[0])
    else $error("request kept after hand-over");

  c_chain_trigger: cover property (@(posedge clock) disable iff (sys_rst) chainSet != '0 ##[1:4] take != '0);
  c_quick_trigger: cover property (@(posedge clock) disable iff (sys_rst) quickHit != '0 ##[1:4] take != '0);
  c_pending_clear: cover property (@(posedge clock) disable iff (sys_rst) pending != '0 ##[1:8] wrClrLow);
  c_final_done: cover property (@(posedge clock) disable iff (sys_rst) doneValid != '0 ##1 pending != '0);
  c_back_to_back: cover property (@(posedge clock) disable iff (sys_rst) handed[0] && take[0]);
endmodule

//--- tb/engine_model.sv
// Behavioural downstream transfer engines, one per queue.
// Assumes the same clock and reset as the channel controller.
`timescale 1ns/1ps
module engine_model #(
  parameter int NQ = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic [5:0] optChan,
  input wire logic [31:0] optWord,
  input wire logic [NQ-1:0] trqValid,
  input wire logic [NQ*6-1:0] trqChannel,
  output logic [NQ-1:0] trqReady,
  output logic [NQ*32-1:0] trqOptions,
  output logic [NQ-1:0] doneValid,
  output logic [NQ*32-1:0] doneOptions
);
  logic [NQ-1:0] acc;
  logic [NQ*32-1:0] held;
  assign trqReady = stall ? '0 : '1;
  // Set RAM answer: one channel carries the test options word
  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      trqOptions[q*32+:32] = (trqChannel[q*6+:6] == optChan) ? optWord : 32'h00000000;
      doneOptions[q*32+:32] = doneValid[q] ? held[q*32+:32] : ~held[q*32+:32];
    end
  end
  // Final completion two cycles after a request is taken
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      acc <= '0;
      doneValid <= '0;
      held <= '0;
    end else begin
      acc <= trqValid & trqReady;
      doneValid <= acc;
      for (int q = 0; q < NQ; q++) begin
        if (trqValid[q] && trqReady[q]) begin
          held[q*32+:32] <= trqOptions[q*32+:32];
        end
      end
    end
  end
endmodule

//--- tb/tb.sv
// Self-checking bench for the channel trigger and completion logic.
// Assumes the engine model answers on the far side of every queue.
`timescale 1ns/1ps
module tb;
  logic clock, sys_rst, regWrite, regRead, ramWrite, linkUpdate, stall;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, optWord, eventPins;
  logic [13:0] ramAddr, linkAddr;
  logic [5:0] optChan;
  logic [7:0] trqValid, trqReady, doneValid;
  logic [47:0] trqChannel;
  logic [255:0] trqOptions, doneOptions;
  int n_fail, compares;
  dma_channel_trigger dut (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .eventPins(eventPins),
    .ramWrite(ramWrite), .ramAddr(ramAddr), .linkUpdate(linkUpdate), .linkAddr(linkAddr),
    .trqValid(trqValid), .trqChannel(trqChannel), .trqReady(trqReady), .trqOptions(trqOptions),
    .doneValid(doneValid), .doneOptions(doneOptions));
  engine_model eng (.clock(clock), .sys_rst(sys_rst), .stall(stall), .optChan(optChan),
    .optWord(optWord), .trqValid(trqValid), .trqChannel(trqChannel), .trqReady(trqReady),
    .trqOptions(trqOptions), .doneValid(doneValid), .doneOptions(doneOptions));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic final_report;
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 check(regRdData, exp);
  endtask
  task automatic pulse(input logic link, input logic [13:0] a);
    @(posedge clock);
    linkUpdate <= link;
    ramWrite <= ~link;
    linkAddr <= a;
    ramAddr <= a;
    @(posedge clock);
    linkUpdate <= 1'b0;
    ramWrite <= 1'b0;
  endtask
  task automatic waitReq(input int q, input logic [5:0] ch);
    int i;
    i = 0;
    do begin
      @(posedge clock);
      #1 i++;
    end while (i < 60 && trqValid[q] !== 1'b1);
    if (i >= 60) begin
      check(32'h00000000, 32'h00000001);
      final_report();
    end
    check({26'h0, trqChannel[q*6+:6]}, {26'h0, ch});
  endtask
  task automatic noReq(input int q);
    repeat (10) begin
      @(posedge clock);
      #1 check({31'h0, trqValid[q]}, 32'h00000000);
    end
  endtask
  task automatic tReset;
    rd(8'h04, 32'h00000000);
    rd(8'h18, 32'h00000000);
    rd(8'h1C, 32'h00000000);
    rd(8'h30, 32'h00000000);
  endtask
  task automatic tManual;
    optChan <= 6'h03;
    optWord <= 32'h00205000;
    wr(8'h08, 32'h00000008);
    waitReq(0, 6'h03);
    repeat (3) @(posedge clock);
    rd(8'h18, 32'h00000020);
    wr(8'h20, 32'h00000000);
    rd(8'h18, 32'h00000020);
    wr(8'h20, 32'h00000020);
    rd(8'h18, 32'h00000000);
  endtask
  task automatic tFinal;
    optChan <= 6'h02;
    optWord <= 32'h00128000;
    wr(8'h08, 32'h00000004);
    waitReq(0, 6'h02);
    repeat (5) @(posedge clock);
    rd(8'h1C, 32'h00000100);
    rd(8'h18, 32'h00000000);
    wr(8'h24, 32'h00000100);
    rd(8'h1C, 32'h00000000);
  endtask
  task automatic tChain;
    for (int k = 0; k < 2; k++) begin
      optChan <= 6'h00;
      optWord <= k ? 32'h00406000 : 32'h00807000;
      wr(8'h08, 32'h00000001);
      waitReq(0, 6'h00);
      waitReq(0, k ? 6'h06 : 6'h07);
    end
  endtask
  task automatic tPin;
    @(posedge clock);
    eventPins[9] <= 1'b1;
    noReq(0);
    rd(8'h00, 32'h00000200);
    wr(8'h04, 32'h00000200);
    waitReq(0, 6'h09);
    @(posedge clock);
    eventPins[9] <= 1'b0;
    rd(8'h00, 32'h00000000);
  endtask
  task automatic tOrder;
    @(posedge clock);
    stall <= 1'b1;
    wr(8'h08, 32'h00000012);
    waitReq(0, 6'h01);
    repeat (4) @(posedge clock);
    #1 check({26'h0, trqChannel[5:0]}, 32'h00000001);
    @(posedge clock);
    stall <= 1'b0;
    waitReq(0, 6'h04);
  endtask
  task automatic tQueue;
    wr(8'h40, 32'h00005000);
    wr(8'h08, 32'h00000008);
    waitReq(5, 6'h03);
  endtask
  task automatic tQuick;
    wr(8'h60, 32'h00020123);
    pulse(1'b0, 14'h0123);
    noReq(2);
    wr(8'h14, 32'h00000001);
    pulse(1'b0, 14'h0123);
    waitReq(2, 6'h20);
    pulse(1'b1, 14'h0123);
    waitReq(2, 6'h20);
    pulse(1'b0, 14'h0124);
    noReq(2);
  endtask
  initial begin
    n_fail = 0;
    compares = 0;
    sys_rst = 1'b1;
    {regWrite, regRead, ramWrite, linkUpdate, stall} = '0;
    {regAddr, regWrData, eventPins, ramAddr, linkAddr, optChan, optWord} = '0;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    tReset();
    tManual();
    tFinal();
    tChain();
    tPin();
    tOrder();
    tQueue();
    tQuick();
    final_report();
  end
endmodule
